// ### ies_bus_model.sv
/*
 * Far side of the transfer error status block: the adapter front end and
 * the other bus parties, reduced to the event strobes the block samples.
 * Assumes the caller enters fire just after a rising edge of aclk.
 */
`timescale 1ns/100ps

module ies_bus_model (
    input wire logic aclk,           // Clock
    output logic stop_detect,        // Stop condition seen
    output logic slave_tx_mode,      // Slave transmit mode
    output logic tx_active,          // Adapter driving data
    output logic bit_sample,         // SDA sampling strobe
    output logic sda_drive,          // Bit driven internally
    output logic sda_in,             // Sampled SDA level
    output logic time_over,          // Timeover strobe
    output logic ack_sample,         // Acknowledge sampling strobe
    output logic received_ack_bit    // Sampled acknowledge level
);
    // SDA and the acknowledge level idle high: the bus has a pull-up
    initial begin
        {stop_detect, slave_tx_mode, tx_active, bit_sample} = 4'h0;
        {sda_drive, time_over, ack_sample} = 3'h0;
        sda_in = 1'b1;
        received_ack_bit = 1'b1;
    end

    // ************************************************************
    // One bus event, held for exactly one cycle
    // ************************************************************
    task automatic fire(input int kind);
        @(posedge aclk);
        case (kind)
            0: {stop_detect, slave_tx_mode} <= 2'h3;
            1: stop_detect <= 1'b1;
            2: {tx_active, bit_sample, sda_drive, sda_in} <= 4'hE;
            3: {tx_active, bit_sample, sda_drive, sda_in} <= 4'hF;
            4: time_over <= 1'b1;
            5: {ack_sample, received_ack_bit} <= 2'h3;
            6: {ack_sample, received_ack_bit} <= 2'h2;
            // Sampling outside a transmission must not count as a mismatch
            default: {tx_active, bit_sample, sda_drive, sda_in} <= 4'h5;
        endcase
        @(posedge aclk);
        {stop_detect, slave_tx_mode, tx_active, bit_sample} <= 4'h0;
        {sda_drive, time_over, ack_sample} <= 3'h0;
        sda_in <= 1'b1;
        received_ack_bit <= 1'b1;
    endtask
endmodule

// ### ies_flag.sv
/*
 * One sticky error flag: set by a hardware event, cleared by a command
 * register write or by writing zero after the flag was read as one.
 * Assumes the strobes are single-cycle and qualified by the bus logic.
 */
`timescale 1ns/100ps

module ies_flag (
    input wire logic aclk,     // Clock
    input wire logic aresetn,  // Synchronous reset, active low
    input wire logic ce,       // Clock enable, freezes state when low
    input wire logic set_evt,  // Hardware event sets the flag
    input wire logic rd_one,   // Status read returned this flag as one
    input wire logic wr_zero,  // Status write carried zero in this bit
    input wire logic cmd_clr,  // Command register was written
    output logic flag          // Current flag value
);

    typedef struct packed {
        logic flag;
        logic armed;
    } ies_flag_state_t;

    ies_flag_state_t st;
    ies_flag_state_t next_st;
    logic clr;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        // A zero write only counts once software has seen the flag set
        clr = cmd_clr | (wr_zero & st.armed);
        if (set_evt) begin
            next_st.flag = 1'b1;
        end else if (clr) begin
            next_st.flag = 1'b0;
        end
        // Writing one never sets the flag: only set_evt can
        if (clr) begin
            next_st.armed = 1'b0;
        end else if (rd_one) begin
            next_st.armed = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign flag = st.flag;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_zero_write_clears;
        @(posedge aclk) disable iff (!aresetn)
        ce && wr_zero && st.armed && !set_evt |=> !flag;
    endproperty
    a_zero_write_clears: assert property (p_zero_write_clears)
        else $error("flag not cleared by zero write after read");

    property p_unread_holds;
        @(posedge aclk) disable iff (!aresetn)
        ce && flag && !st.armed && !cmd_clr |=> flag;
    endproperty
    a_unread_holds: assert property (p_unread_holds)
        else $error("flag cleared without prior read or command write");

    property p_set_wins;
        @(posedge aclk) disable iff (!aresetn)
        ce && set_evt |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("set event lost against a clear");

endmodule

// ### ies_pkg.sv
/*
 * Package of the transfer error status block: register offsets, flag bit
 * positions, reset values and AXI4-Lite response codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package ies_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CMD = 4'h4;
    localparam logic [3:0] ADDR_INT_STATUS = 4'h8;
    localparam logic [3:0] ADDR_INT_MASK = 4'hC;

    // ************************************************************
    // Flag positions in the status, interrupt status and mask words
    // ************************************************************
    localparam int NUM_FLAGS = 3;
    localparam int BIT_RECEIVED_FLAG_A = 0;
    localparam int BIT_TIME_OVER = 1;
    localparam int BIT_TX_MISMATCH = 2;
    localparam int CMD_WIDTH = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [2:0] RST_INT_MASK = 3'h0;
    localparam logic [7:0] RST_CMD = 8'h00;

    // ************************************************************
    // AXI4-Lite responses
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### ies_top.sv
/*
 * Transfer error status block with an AXI4-Lite register slave.
 * Assumes the event inputs are synchronous to aclk and one cycle wide.
 */
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
// Operation
// - Stop in slave transmit sets mismatch flag.
// - Driven bit differing from SDA sets mismatch.
// - Zero write after reading one clears mismatch.
// - Command register write clears all three flags.
// - Timeover event sets the timeover flag.
// - Zero write after reading one clears timeover.
// - High acknowledge after transmission sets RECEIVED_FLAG_A flag.
// - Zero write after reading one clears RECEIVED_FLAG_A.
// - Software writes can only clear the flags.
`timescale 1ns/100ps

module ies_top #(
    parameter int ADDR_WIDTH = 4
) (
    input wire logic aclk,                      // Clock, 100 MHz
    input wire logic aresetn,                   // Synchronous reset, active low
    input wire logic ce,                        // Clock enable
    // AXI4-Lite slave
    input wire logic [ADDR_WIDTH-1:0] awaddr,   // Write address
    input wire logic awvalid,                   // Write address valid
    output logic awready,                       // Write address ready
    input wire logic [31:0] wdata,              // Write data
    input wire logic [3:0] wstrb,               // Write byte strobes
    input wire logic wvalid,                    // Write data valid
    output logic wready,                        // Write data ready
    output logic [1:0] bresp,                   // Write response
    output logic bvalid,                        // Write response valid
    input wire logic bready,                    // Write response ready
    input wire logic [ADDR_WIDTH-1:0] araddr,   // Read address
    input wire logic arvalid,                   // Read address valid
    output logic arready,                       // Read address ready
    output logic [31:0] rdata,                  // Read data
    output logic [1:0] rresp,                   // Read response
    output logic rvalid,                        // Read data valid
    input wire logic rready,                    // Read data ready
    // Bus-side events
    input wire logic stop_detect,               // Stop condition seen on the bus
    input wire logic slave_tx_mode,             // Adapter is in slave transmit
    input wire logic tx_active,                 // Adapter is driving data
    input wire logic bit_sample,                // SDA sampling point strobe
    input wire logic sda_drive,                 // Bit the adapter drives internally
    input wire logic sda_in,                    // Sampled SDA pin level
    input wire logic time_over,                 // Timeover event strobe
    input wire logic ack_sample,                // Acknowledge bit after data sampled
    input wire logic received_ack_bit,          // Sampled acknowledge bit level
    // Status outputs
    output logic [2:0] error_flags,             // Mismatch, timeover, RECEIVED_FLAG_A flags
    output logic [7:0] command_register,        // Last command written
    output logic irq                            // Level interrupt
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (ADDR_WIDTH < 4) begin : g_bad_width
        $error("ADDR_WIDTH must be at least 4");
    end

    typedef struct packed {
        logic aw_held;
        logic [ADDR_WIDTH-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] cmd;
        logic [2:0] int_status;
        logic [2:0] int_mask;
    } ies_top_state_t;

    ies_top_state_t st;
    ies_top_state_t next_st;

    logic [2:0] events;
    logic [2:0] flags;
    logic do_wr;
    logic do_rd;
    logic [3:0] wr_addr;
    logic [3:0] rd_addr;
    logic wr_status;
    logic wr_cmd;
    logic [2:0] rd_one;
    logic [2:0] wr_zero;
    logic [31:0] rd_word;
    logic rd_hit;

    // ************************************************************
    // Event detection
    // ************************************************************
    always_comb begin
        events = '0;
        // Stop in slave transmit; software may disregard it alongside stop
        events[ies_pkg::BIT_TX_MISMATCH] = (stop_detect & slave_tx_mode)
            | (tx_active & bit_sample & (sda_drive != sda_in));
        events[ies_pkg::BIT_TIME_OVER] = time_over;
        events[ies_pkg::BIT_RECEIVED_FLAG_A] = ack_sample & received_ack_bit;
    end

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign awready = !st.aw_held && !st.bvalid;
    assign wready = !st.w_held && !st.bvalid;
    assign arready = !st.rvalid;
    assign do_wr = st.aw_held && st.w_held && !st.bvalid;
    assign do_rd = arvalid && arready;
    assign wr_addr = st.aw_addr[3:0];
    assign rd_addr = araddr[3:0];
    // Status and command live in byte lane 0; other lanes are ignored
    assign wr_status = do_wr && st.w_strb[0] && (wr_addr == ies_pkg::ADDR_STATUS)
        && (st.aw_addr[ADDR_WIDTH-1:0] >> 4 == '0);
    assign wr_cmd = do_wr && st.w_strb[0] && (wr_addr == ies_pkg::ADDR_CMD)
        && (st.aw_addr[ADDR_WIDTH-1:0] >> 4 == '0);

    always_comb begin
        rd_word = '0;
        rd_hit = (araddr >> 4) == '0;
        case (rd_addr)
            ies_pkg::ADDR_STATUS: rd_word[2:0] = flags;
            ies_pkg::ADDR_CMD: rd_word[7:0] = st.cmd;
            ies_pkg::ADDR_INT_STATUS: rd_word[2:0] = st.int_status;
            ies_pkg::ADDR_INT_MASK: rd_word[2:0] = st.int_mask;
            default: rd_hit = 1'b0;
        endcase
        if (!rd_hit) begin
            rd_word = '0;
        end
    end

    // Reading a one arms that flag for a later zero write
    assign rd_one = (do_rd && rd_hit && rd_addr == ies_pkg::ADDR_STATUS) ? flags : 3'h0;
    assign wr_zero = wr_status ? ~st.w_data[2:0] : 3'h0;

    // ************************************************************
    // Error flags
    // ************************************************************
    for (genvar i = 0; i < ies_pkg::NUM_FLAGS; i++) begin : g_flag
        ies_flag u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .set_evt(events[i]),
            .rd_one(rd_one[i]),
            .wr_zero(wr_zero[i]),
            .cmd_clr(wr_cmd),
            .flag(flags[i])
        );
    end

    // ************************************************************
    // Register and bus state
    // ************************************************************
    always_comb begin
        logic wr_hit;
        wr_hit = 1'b0;
        next_st = st;
        if (awvalid && awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        if (do_wr) begin
            wr_hit = (st.aw_addr >> 4) == '0;
            case (wr_addr)
                ies_pkg::ADDR_STATUS: ;
                ies_pkg::ADDR_CMD: begin
                    if (st.w_strb[0]) begin
                        next_st.cmd = st.w_data[7:0];
                    end
                end
                ies_pkg::ADDR_INT_STATUS: begin
                    if (st.w_strb[0]) begin
                        next_st.int_status = st.int_status & ~st.w_data[2:0];
                    end
                end
                ies_pkg::ADDR_INT_MASK: begin
                    if (st.w_strb[0]) begin
                        next_st.int_mask = st.w_data[2:0];
                    end
                end
                default: wr_hit = 1'b0;
            endcase
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_hit ? ies_pkg::RESP_OKAY : ies_pkg::RESP_SLVERR;
        end else if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        // Events win over a write-one clear of the same bit
        next_st.int_status = next_st.int_status | events;
        if (do_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = rd_hit ? ies_pkg::RESP_OKAY : ies_pkg::RESP_SLVERR;
        end else if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.cmd <= ies_pkg::RST_CMD;
            st.int_status <= ies_pkg::RST_FLAGS;
            st.int_mask <= ies_pkg::RST_INT_MASK;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign error_flags = flags;
    assign command_register = st.cmd;
    assign irq = |(st.int_status & st.int_mask);

    // ************************************************************
    // Checks
    // ************************************************************
    property p_stop_sets;
        @(posedge aclk) disable iff (!aresetn)
        ce && stop_detect && slave_tx_mode |=> error_flags[2];
    endproperty
    a_stop_sets: assert property (p_stop_sets)
        else $error("stop in slave transmit did not set mismatch flag");

    property p_mismatch_sets;
        @(posedge aclk) disable iff (!aresetn)
        ce && tx_active && bit_sample && (sda_drive != sda_in) |=> error_flags[2];
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets)
        else $error("SDA mismatch did not set mismatch flag");

    property p_timeover_sets;
        @(posedge aclk) disable iff (!aresetn)
        ce && time_over |=> error_flags[1];
    endproperty
    a_timeover_sets: assert property (p_timeover_sets)
        else $error("timeover did not set timeover flag");

    property p_received_flag_a_sets;
        @(posedge aclk) disable iff (!aresetn)
        ce && ack_sample && received_ack_bit |=> error_flags[0];
    endproperty
    a_received_flag_a_sets: assert property (p_received_flag_a_sets)
        else $error("high acknowledge did not set RECEIVED_FLAG_A flag");

    property p_cmd_clears;
        @(posedge aclk) disable iff (!aresetn)
        ce && wr_cmd && (events == 3'h0) |=> (error_flags == 3'h0);
    endproperty
    a_cmd_clears: assert property (p_cmd_clears)
        else $error("command write did not clear the flags");

    property p_only_events_set;
        @(posedge aclk) disable iff (!aresetn)
        ce && (events == 3'h0) |=> ((error_flags & ~$past(error_flags)) == 3'h0);
    endproperty
    a_only_events_set: assert property (p_only_events_set)
        else $error("flag set without a hardware event");

    property p_irq_follows;
        @(posedge aclk) disable iff (!aresetn)
        ce && |(events & st.int_mask) && !(do_wr && wr_addr == ies_pkg::ADDR_INT_MASK)
        |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("unmasked event did not raise the interrupt");

    property p_bvalid_holds;
        @(posedge aclk) disable iff (!aresetn)
        ce && bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bvalid_holds: assert property (p_bvalid_holds)
        else $error("write response dropped before acceptance");

    // A low enable must swallow events and writes alike
    property p_ce_freezes;
        @(posedge aclk) disable iff (!aresetn)
        !ce |=> $stable(error_flags) && $stable(command_register);
    endproperty
    a_ce_freezes: assert property (p_ce_freezes)
        else $error("state changed while the clock enable was low");

endmodule

// ### test_i2c_error_status_flags.sv
/*
 * Self-checking bench of the transfer error status block over AXI4-Lite.
 * Assumes the package register map and the one-cycle event strobes.
 */
`timescale 1ns/100ps

module test_i2c_error_status_flags;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [3:0] araddr = 4'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic stop_detect, slave_tx_mode, tx_active, bit_sample, sda_drive, sda_in;
    logic time_over, ack_sample, received_ack_bit, irq;
    logic [2:0] error_flags;
    logic [7:0] command_register;
    logic [31:0] last_data;
    logic [1:0] last_resp;
    logic [2:0] kind_flags [8] = '{3'h4, 3'h0, 3'h4, 3'h0, 3'h2, 3'h1, 3'h0, 3'h0};
    int error_cnt = 0;
    int num_checks = 0;

    always #5 aclk = ~aclk;

    ies_bus_model bus (.aclk(aclk), .stop_detect(stop_detect), .slave_tx_mode(slave_tx_mode),
        .tx_active(tx_active), .bit_sample(bit_sample), .sda_drive(sda_drive),
        .sda_in(sda_in), .time_over(time_over), .ack_sample(ack_sample),
        .received_ack_bit(received_ack_bit));

    ies_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .stop_detect(stop_detect), .slave_tx_mode(slave_tx_mode), .tx_active(tx_active),
        .bit_sample(bit_sample), .sda_drive(sda_drive), .sda_in(sda_in),
        .time_over(time_over), .ack_sample(ack_sample),
        .received_ack_bit(received_ack_bit), .error_flags(error_flags),
        .command_register(command_register), .irq(irq));

    // ************************************************************
    // Compare, verdict and bus tasks
    // ************************************************************
    task automatic close_out();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Irq and the three flags together, once the edge's updates have landed
    task automatic chk(input logic [3:0] exp);
        #1;
        check({28'h0, irq, error_flags}, {28'h0, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                last_resp = bresp;
                bready <= 1'b0;
                return;
            end
            // Accept one cycle late so the slave has to hold its response
            if (bvalid) bready <= 1'b1;
        end
        error_cnt++;
        close_out();
    endtask

    task automatic rd(input logic [3:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                last_data = rdata;
                last_resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        error_cnt++;
        close_out();
    endtask

    task automatic set_all();
        bus.fire(0);
        bus.fire(4);
        bus.fire(5);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(4'h0);
        rd(ies_pkg::ADDR_STATUS);
        check(last_data, 32'h0);
        rd(ies_pkg::ADDR_INT_MASK);
        check(last_data, 32'h0);
        // Kind 0 also raises stop_detect; software discards that pairing
        for (int k = 0; k < 8; k++) begin
            bus.fire(k);
            chk({1'b0, kind_flags[k]});
            wr(ies_pkg::ADDR_CMD, 32'h0, 4'hF);
            chk(4'h0);
        end
        set_all();
        wr(ies_pkg::ADDR_STATUS, 32'h0, 4'hF);
        chk(4'h7);
        rd(ies_pkg::ADDR_STATUS);
        check(last_data, 32'h7);
        wr(ies_pkg::ADDR_STATUS, 32'h6, 4'hF);
        chk(4'h6);
        wr(ies_pkg::ADDR_STATUS, 32'h5, 4'hF);
        chk(4'h4);
        wr(ies_pkg::ADDR_STATUS, 32'h3, 4'hF);
        chk(4'h0);
        set_all();
        rd(ies_pkg::ADDR_STATUS);
        // Timeover lands on the very edge that applies the clearing write
        fork
            wr(ies_pkg::ADDR_STATUS, 32'h0, 4'hF);
            begin
                @(posedge aclk);
                bus.fire(4);
            end
        join
        chk(4'h2);
        set_all();
        wr(ies_pkg::ADDR_CMD, 32'h5A, 4'hF);
        chk(4'h0);
        check({30'h0, last_resp}, {30'h0, ies_pkg::RESP_OKAY});
        check({24'h0, command_register}, 32'h5A);
        rd(ies_pkg::ADDR_CMD);
        check(last_data, 32'h5A);
        set_all();
        wr(ies_pkg::ADDR_CMD, 32'hA5, 4'h0);
        chk(4'h7);
        wr(ies_pkg::ADDR_INT_STATUS, 32'h7, 4'hF);
        wr(ies_pkg::ADDR_CMD, 32'h0, 4'hF);
        bus.fire(4);
        chk(4'h2);
        wr(ies_pkg::ADDR_INT_MASK, 32'h2, 4'hF);
        chk(4'hA);
        rd(ies_pkg::ADDR_INT_STATUS);
        check(last_data, 32'h2);
        wr(ies_pkg::ADDR_INT_STATUS, 32'h2, 4'hF);
        chk(4'h2);
        rd(4'h2);
        check({30'h0, last_resp}, {30'h0, ies_pkg::RESP_SLVERR});
        check(last_data, 32'h0);
        wr(4'h6, 32'h0, 4'hF);
        check({30'h0, last_resp}, {30'h0, ies_pkg::RESP_SLVERR});
        chk(4'h2);
        wr(ies_pkg::ADDR_CMD, 32'h0, 4'hF);
        // An event while the clock enable is low must be lost
        @(posedge aclk);
        ce <= 1'b0;
        bus.fire(4);
        ce <= 1'b1;
        chk(4'h0);
        bus.fire(4);
        chk(4'hA);
        // Reset in mid-run clears a set flag and the interrupt
        @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        chk(4'h0);
        close_out();
    end
endmodule
